// ---- isp_consts.vh ----
// Constants for the inclinometer serial port target
`ifndef ISP_CONSTS_VH
`define ISP_CONSTS_VH
`define ISP_FRAME_BITS      5'h10
`define ISP_ADDR_W          6
`define ISP_ADDR_MSB        13
`define ISP_ADDR_LSB        8
`define ISP_WR_BIT          15
`define ISP_RW_BIT          14
`define ISP_FAST_LIMIT      8'h07
`define ISP_SMPL_ADDR       6'h36
`define ISP_SMPL_RESET      8'h01
`define ISP_BUF_DEPTH       2'h2
`define ISP_MSB             15
`define ISP_DATA_MSB        7
`define ISP_DATA_LSB        0
`define ISP_CNT_ZERO        5'h00
`define ISP_CNT_STEP        5'h01
`define ISP_CNT_LAST        5'h0F
`define ISP_SYNC_IDLE       2'h3
`endif

// ---- isp_buf.v ----
// Two-entry valid/ready buffer for write words
`timescale 1ns/1ps
`include "isp_consts.vh"
module isp_buf (
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Fill side
    input  wire        in_valid,
    output wire        in_ready,
    input  wire [13:0] in_data,
    // Drain side
    output wire        out_valid,
    input  wire        out_ready,
    output wire [13:0] out_data
);
    reg  [13:0] mem_ff [0:1];
    reg         wp_ff;
    reg         rp_ff;
    reg  [1:0]  cnt_ff;
    wire        push = in_valid && in_ready;
    wire        pop  = out_valid && out_ready;

    assign in_ready  = (cnt_ff != `ISP_BUF_DEPTH);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data  = mem_ff[rp_ff];

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wp_ff     <= 1'b0;
            rp_ff     <= 1'b0;
            cnt_ff    <= 2'h0;
            mem_ff[0] <= 14'h0000;
            mem_ff[1] <= 14'h0000;
        end else begin
            if (push) begin
                mem_ff[wp_ff] <= in_data;
                wp_ff         <= ~wp_ff;
            end
            if (pop)
                rp_ff <= ~rp_ff;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ---- isp_target.v ----
// Serial port target: framing, shifting and register access
// Contract
// - MSB driven at chip select fall
// - Later bits shift after clock fall
// - Input bits captured on clock rise
// - Output released while chip select high
// - Transfer exists only while select low
// - Reset returns controller to initial state; rst_n leaves the write buffer and its words as they are
// - Frame is exactly 16 clocks, full duplex
// - Read returns 16-bit content next frame
`timescale 1ns/1ps
`include "isp_consts.vh"
module isp_target (
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    input  wire        rst_n,
    // Serial link pins
    input  wire        sclk,
    input  wire        cs_n,
    input  wire        din,
    output wire        dout,
    output wire        dout_oe,
    // Register file side
    output wire [5:0]  rd_addr,
    input  wire [15:0] rd_data,
    output wire        wr_valid,
    input  wire        wr_ready,
    output wire [5:0]  wr_addr,
    output wire [7:0]  wr_data,
    output wire        wr_stall,
    // Mode
    output wire [7:0]  sample_period_setting,
    output wire        fast_mode
);
    //------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------
    // Only the second stage of each pair is read by logic, so a
    // metastable first stage never fans out.
    reg  [1:0]  sclk_s_ff;
    reg  [1:0]  cs_s_ff;
    reg  [1:0]  din_s_ff;
    reg  [1:0]  rst_s_ff;
    wire        sclk_q;
    wire        cs_q;
    wire        din_q;
    wire        soft_rst;

    assign sclk_q   = sclk_s_ff[1];
    assign cs_q     = cs_s_ff[1];
    assign din_q    = din_s_ff[1];
    assign soft_rst = ~rst_s_ff[1];

    // Clock and select come out of reset at their idle levels, so
    // no false edge follows reset.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sclk_s_ff <= `ISP_SYNC_IDLE;
            cs_s_ff   <= `ISP_SYNC_IDLE;
            din_s_ff  <= 2'h0;
            rst_s_ff  <= 2'h0;
        end else begin
            sclk_s_ff <= {sclk_s_ff[0], sclk};
            cs_s_ff   <= {cs_s_ff[0], cs_n};
            din_s_ff  <= {din_s_ff[0], din};
            rst_s_ff  <= {rst_s_ff[0], rst_n};
        end
    end

    //------------------------------------------------------------
    // Frame state
    //------------------------------------------------------------
    reg         sclk_d_ff;
    reg         cs_d_ff;
    reg  [4:0]  cnt_ff;
    reg  [15:0] rx_ff;
    reg  [15:0] tx_ff;
    reg  [5:0]  rd_addr_ff;
    reg         dout_ff;
    reg         dout_oe_ff;
    reg  [7:0]  setting_ff;
    reg  [4:0]  nxt_cnt;
    reg  [15:0] nxt_rx;
    reg  [15:0] nxt_tx;
    reg  [5:0]  nxt_rd_addr;
    reg         nxt_dout;
    reg         nxt_dout_oe;
    reg  [7:0]  nxt_setting;
    wire        cs_fall;
    wire        sck_rise;
    wire        sck_fall;
    wire        done;
    wire [15:0] word;
    wire        is_write;
    wire        is_read;
    wire        hit_setting;
    wire        in_ready;
    wire [13:0] buf_out;

    //------------------------------------------------------------
    // Edge detection and command decode
    //------------------------------------------------------------
    // Edges are qualified by select, so clock and data activity
    // while deselected never reaches the shifter.
    assign cs_fall     = cs_d_ff && !cs_q;
    assign sck_rise    = !sclk_d_ff && sclk_q && !cs_q;
    assign sck_fall    = sclk_d_ff && !sclk_q && !cs_q;
    // The last bit is still in the synchroniser when the final rise
    // is seen, so the whole word is assembled from it here.
    assign word        = {rx_ff[`ISP_MSB - 1:0], din_q};
    assign done        = sck_rise && (cnt_ff == `ISP_CNT_LAST);
    assign is_write    = word[`ISP_WR_BIT] && !word[`ISP_RW_BIT];
    assign is_read     = !word[`ISP_WR_BIT] && !word[`ISP_RW_BIT];
    assign hit_setting = (word[`ISP_ADDR_MSB:`ISP_ADDR_LSB] == `ISP_SMPL_ADDR);

    //------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------
    // Idle-high clock means a frame opens with a fall; that first
    // fall must not shift, because the MSB went out with select.
    always @* begin
        nxt_cnt     = cnt_ff;
        nxt_rx      = rx_ff;
        nxt_tx      = tx_ff;
        nxt_rd_addr = rd_addr_ff;
        nxt_dout    = dout_ff;
        nxt_dout_oe = dout_oe_ff;
        nxt_setting = setting_ff;
        if (cs_q) begin
            nxt_dout_oe = 1'b0;
            nxt_cnt     = `ISP_CNT_ZERO;
        end else if (cs_fall) begin
            nxt_tx      = rd_data;
            nxt_dout    = rd_data[`ISP_MSB];
            nxt_dout_oe = 1'b1;
            nxt_cnt     = `ISP_CNT_ZERO;
        end else begin
            if (sck_fall && cnt_ff != `ISP_CNT_ZERO) begin
                nxt_dout = tx_ff[`ISP_MSB - 1];
                nxt_tx   = {tx_ff[`ISP_MSB - 1:0], 1'b0};
            end
            if (sck_rise) begin
                nxt_rx  = word;
                nxt_cnt = done ? `ISP_CNT_ZERO : cnt_ff + `ISP_CNT_STEP;
            end
            if (done && is_read) begin
                nxt_rd_addr = word[`ISP_ADDR_MSB:`ISP_ADDR_LSB];
            end
            // A full buffer refuses the whole write, setting included,
            // so one stall flag tells the host that the word was lost.
            if (done && is_write && in_ready && hit_setting) begin
                nxt_setting = word[`ISP_DATA_MSB:`ISP_DATA_LSB];
            end
        end
    end

    //------------------------------------------------------------
    // State registers
    //------------------------------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sclk_d_ff  <= 1'b1;
            cs_d_ff    <= 1'b1;
            cnt_ff     <= `ISP_CNT_ZERO;
            rx_ff      <= 16'h0000;
            tx_ff      <= 16'h0000;
            rd_addr_ff <= 6'h00;
            dout_ff    <= 1'b0;
            dout_oe_ff <= 1'b0;
            setting_ff <= `ISP_SMPL_RESET;
        end else if (soft_rst) begin
            sclk_d_ff  <= 1'b1;
            cs_d_ff    <= 1'b1;
            cnt_ff     <= `ISP_CNT_ZERO;
            rx_ff      <= 16'h0000;
            tx_ff      <= 16'h0000;
            rd_addr_ff <= 6'h00;
            dout_ff    <= 1'b0;
            dout_oe_ff <= 1'b0;
            setting_ff <= `ISP_SMPL_RESET;
        end else begin
            sclk_d_ff  <= sclk_q;
            cs_d_ff    <= cs_q;
            cnt_ff     <= nxt_cnt;
            rx_ff      <= nxt_rx;
            tx_ff      <= nxt_tx;
            rd_addr_ff <= nxt_rd_addr;
            dout_ff    <= nxt_dout;
            dout_oe_ff <= nxt_dout_oe;
            setting_ff <= nxt_setting;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    assign dout                  = dout_ff;
    assign dout_oe               = dout_oe_ff;
    assign rd_addr               = rd_addr_ff;
    assign sample_period_setting = setting_ff;
    assign fast_mode             = (setting_ff <= `ISP_FAST_LIMIT);
    assign wr_stall              = !in_ready;
    assign wr_addr               = buf_out[`ISP_ADDR_MSB:`ISP_ADDR_LSB];
    assign wr_data               = buf_out[`ISP_DATA_MSB:`ISP_DATA_LSB];

    //------------------------------------------------------------
    // Write buffer
    //------------------------------------------------------------
    // A full buffer drops the word and raises stall; the host must
    // watch stall, since nothing on the serial link reports it.
    isp_buf u_buf (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (done && is_write),
        .in_ready  (in_ready),
        .in_data   (word[`ISP_ADDR_MSB:0]),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (buf_out)
    );
endmodule

// ---- isp_target_props.sv ----
// Checker for the serial port target
`timescale 1ns/1ps
module isp_target_props (
    // Clock and resets
    input wire       clk,
    input wire       reset,
    input wire       rst_n,
    // Observed ports
    input wire       cs_n,
    input wire       sclk,
    input wire       dout,
    input wire       dout_oe,
    input wire       wr_valid,
    input wire       wr_stall,
    input wire [7:0] sample_period_setting,
    input wire       fast_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence oe_up;
        ##[3:4] dout_oe;
    endsequence
    msb_drive_a: assert property ($fell(cs_n) |-> oe_up) else $error("no drive");
    shift_fall_a: assert property (dout_oe && $past(dout_oe) && $changed(dout) |->
        !$past(sclk, 3) || !$past(sclk, 4)) else $error("bad shift");
    oe_release_a: assert property ($rose(cs_n) |-> ##[3:4] !dout_oe) else $error("kept drive");
    idle_quiet_a: assert property (cs_n[*5] |-> !dout_oe && !$rose(wr_valid)) else $error("idle act");
    oe_frame_a: assert property ($rose(dout_oe) |-> !cs_n) else $error("drive unframed");
    rst_init_a: assert property (!rst_n[*4] |-> !dout_oe && !wr_valid && sample_period_setting == 8'h01)
        else $error("reset state");
    mode_flag_a: assert property (fast_mode == (sample_period_setting <= 8'h07)) else $error("mode");
    stall_full_a: assert property (wr_stall |-> wr_valid) else $error("stall empty");
endmodule
bind isp_target isp_target_props u_props (.*);

// ---- isp_host.sv ----
// Host model driving the serial link
`timescale 1ns/1ps
module isp_host (
    // Clock and mode
    input  wire clk,
    input  wire fast_mode,
    // Serial link
    output reg  sclk,
    output reg  cs_n,
    output reg  din,
    input  wire dout_pin
);
    integer i;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    task xfer(input [15:0] tx, output [15:0] rx);
        begin
            @(posedge clk) cs_n <= 1'b0;
            repeat (4) @(posedge clk);
            for (i = 15; i >= 0; i = i - 1) begin
                sclk <= 1'b0;
                din  <= tx[i];
                repeat (4) @(posedge clk);
                sclk <= 1'b1;
                repeat (2) @(posedge clk);
                rx[i] = dout_pin;
                repeat (2) @(posedge clk);
            end
            cs_n <= 1'b1;
            // Released line must not keep its last value
            din  <= ~din;
            repeat (fast_mode ? 1900 : 4900) @(posedge clk);
        end
    endtask
endmodule

// ---- isp_target_test.sv ----
// Self-checking bench for the serial port target
`timescale 1ns/1ps
module isp_target_test;
    reg         clk = 1'b0;
    reg         reset = 1'b1;
    reg         rst_n = 1'b1;
    reg         wr_ready = 1'b0;
    reg  [15:0] rd_data = 16'h0000;
    reg  [15:0] rx;
    wire        sclk, cs_n, din, dout, dout_oe, wr_valid, wr_stall, fast_mode;
    wire [5:0]  rd_addr, wr_addr;
    wire [7:0]  wr_data, sample_period_setting;
    integer     mismatches = 0;
    integer     total_checks = 0;
    integer     cycles = 0;
    always #10 clk = ~clk;
    isp_target u_dut (
        .clk                   (clk),
        .reset                 (reset),
        .rst_n                 (rst_n),
        .sclk                  (sclk),
        .cs_n                  (cs_n),
        .din                   (din),
        .dout                  (dout),
        .dout_oe               (dout_oe),
        .rd_addr               (rd_addr),
        .rd_data               (rd_data),
        .wr_valid              (wr_valid),
        .wr_ready              (wr_ready),
        .wr_addr               (wr_addr),
        .wr_data               (wr_data),
        .wr_stall              (wr_stall),
        .sample_period_setting (sample_period_setting),
        .fast_mode             (fast_mode)
    );
    // A released data line shows the inverse, never its last bit
    isp_host u_host (
        .clk       (clk),
        .fast_mode (fast_mode),
        .sclk      (sclk),
        .cs_n      (cs_n),
        .din       (din),
        .dout_pin  (dout_oe ? dout : ~dout)
    );
    always @(posedge clk) rd_data <= {4'hC, rd_addr, ~rd_addr};
    task chk(input [15:0] got, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: %h not %h", $time, got, exp);
            end
        end
    endtask
    task test_done;
        begin
            if (mismatches == 0 && total_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            test_done;
        end
    end
    task t_read;
        begin
            u_host.xfer(16'h1500, rx);
            u_host.xfer(16'h2A00, rx);
            chk(rx, {4'hC, 6'h15, 6'h2A});
            chk({15'h0000, dout_oe}, 16'h0000);
        end
    endtask
    task t_write;
        begin
            u_host.xfer(16'h853C, rx);
            u_host.xfer(16'h86C3, rx);
            u_host.xfer(16'h8711, rx);
            chk({wr_stall, wr_valid, wr_addr, wr_data}, {2'h3, 6'h05, 8'h3C});
            @(posedge clk) wr_ready <= 1'b1;
            @(posedge clk) wr_ready <= 1'b0;
            #1 chk({wr_valid, wr_addr, wr_data}, {1'b1, 6'h06, 8'hC3});
            @(posedge clk) wr_ready <= 1'b1;
            repeat (2) @(posedge clk);
            #1 chk({15'h0000, wr_valid}, 16'h0000);
        end
    endtask
    task t_mode;
        begin
            u_host.xfer(16'hB608, rx);
            chk({wr_valid, fast_mode, sample_period_setting}, {2'h0, 8'h08});
            @(posedge clk) rst_n <= 1'b0;
            repeat (4) @(posedge clk);
            rst_n <= 1'b1;
            #1 chk({fast_mode, sample_period_setting}, {1'b1, 8'h01});
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        t_read;
        t_write;
        t_mode;
        test_done;
    end
endmodule
